// ==== rtl/sysref_defs.vh ====
`ifndef SYSREF_DEFS_VH
`define SYSREF_DEFS_VH

// ==========================================
// register byte offsets
`define OFS_CONFIG        8'h00
`define OFS_PULSE_COUNT   8'h04
`define OFS_RATE_DIVIDER  8'h08
`define OFS_COINCIDENCE   8'h0c
`define OFS_RELEASE       8'h10
`define OFS_STATUS        8'h14
`define OFS_SYSREF_DELAY  8'h18

// ==========================================
// config field positions
`define CFG_SOURCE_SELECT     0
`define CFG_CONTINUOUS_SELECT 1
`define CFG_IDLE_BIAS_BIT     2
`define CFG_BIAS_TYPE         3
`define CFG_VCXO_LOOP_BYPASS  4
`define CFG_SYNTH_LOOP_BYPASS 5
`define CFG_WIDTH             6

// ==========================================
// reset values
`define RST_CONFIG        6'h00
`define RST_PULSE_COUNT   8'h01
`define RST_RATE_DIVIDER  4'h0
`define RST_COINCIDENCE   7'h01
`define RST_SYSREF_DELAY  8'h00

// ==========================================
// rate divider codes to ratios
`define RATIO_0   13'h0040
`define RATIO_1   13'h0060
`define RATIO_2   13'h0080
`define RATIO_3   13'h00c0
`define RATIO_4   13'h0100
`define RATIO_5   13'h0180
`define RATIO_6   13'h0200
`define RATIO_7   13'h0300
`define RATIO_8   13'h0400
`define RATIO_9   13'h0800
`define RATIO_10  13'h1000
`define RATIO_11  13'h1400

// ==========================================
// phase-ahead limit for the shared sysref delay
`define PHASE_AHEAD_MAX   8'h01

`endif

// ==== rtl/trigger_sync.v ====
`default_nettype none

// ==========================================
// trigger synchroniser and rising edge
module trigger_sync (
   // clock and reset
   input  wire clk,
   input  wire rst,
   // pin side
   input  wire trigger_pin,
   // logic side
   output reg  rise
);

   reg meta;
   reg sync;
   reg sync_prev;

   // first flop read only by the second
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta      <= 1'b0;
         sync      <= 1'b0;
         sync_prev <= 1'b0;
         rise      <= 1'b0;
      end else begin
         meta      <= trigger_pin;
         sync      <= meta;
         sync_prev <= sync;
         rise      <= sync & ~sync_prev;
      end
   end

endmodule // trigger_sync

`default_nettype wire

// ==== rtl/sysref_rate_gen.v ====
`default_nettype none
`include "sysref_defs.vh"

// ==========================================
// coincidence and pulse-rate timing
module sysref_rate_gen (
   // clock and reset
   input  wire        clk,
   input  wire        rst,
   // control
   input  wire        run,
   input  wire [3:0]  rate_code,
   input  wire [6:0]  coin_div,
   // timing
   output wire        coin_tick,
   output wire        period_end,
   output wire        high_phase
);

   reg  [6:0]  coin_cnt;
   reg  [12:0] rate_cnt;
   reg  [12:0] ratio;
   wire [6:0]  coin_last;

   // out-of-table codes fall back to the slowest rate
   always @* begin
      case (rate_code)
         4'h0:    ratio = `RATIO_0;
         4'h1:    ratio = `RATIO_1;
         4'h2:    ratio = `RATIO_2;
         4'h3:    ratio = `RATIO_3;
         4'h4:    ratio = `RATIO_4;
         4'h5:    ratio = `RATIO_5;
         4'h6:    ratio = `RATIO_6;
         4'h7:    ratio = `RATIO_7;
         4'h8:    ratio = `RATIO_8;
         4'h9:    ratio = `RATIO_9;
         4'ha:    ratio = `RATIO_10;
         default: ratio = `RATIO_11;
      endcase
   end

   // zero divider acts as divide by one
   assign coin_last = (coin_div == 7'h00) ? 7'h00 : coin_div - 7'h01;

   // free-running coincidence counter
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         coin_cnt <= 7'h00;
      end else if (coin_cnt >= coin_last) begin
         coin_cnt <= 7'h00;
      end else begin
         coin_cnt <= coin_cnt + 7'h01;
      end
   end

   assign coin_tick = (coin_cnt == 7'h00);

   // period counter restarts each run
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rate_cnt <= 13'h0000;
      end else if (!run || period_end) begin
         rate_cnt <= 13'h0000;
      end else begin
         rate_cnt <= rate_cnt + 13'h0001;
      end
   end

   assign period_end = run && (rate_cnt == ratio - 13'h0001);
   assign high_phase = run && (rate_cnt < {1'b0, ratio[12:1]});

endmodule // sysref_rate_gen

`default_nettype wire

// ==== rtl/sysref_pulse_gen.v ====
`default_nettype none
`include "sysref_defs.vh"

module sysref_pulse_gen #(
   parameter NUM_OUTPUTS = 4
) (
   // clock and reset
   input  wire                   clk,
   input  wire                   rst,
   // apb slave
   input  wire                   psel,
   input  wire                   penable,
   input  wire                   pwrite,
   input  wire [7:0]             paddr,
   input  wire [31:0]            pwdata,
   output reg  [31:0]            prdata,
   output reg                    pready,
   output reg                    pslverr,
   // trigger pin
   input  wire                   external_sysref_trigger,
   // sysref outputs
   output reg  [NUM_OUTPUTS-1:0] sysref_output,
   output reg  [NUM_OUTPUTS-1:0] sysref_output_enable,
   output reg  [NUM_OUTPUTS-1:0] sysref_idle_bias,
   // alignment status
   output reg                    sysref_phase_ahead,
   output reg                    deterministic_delay
);

   localparam ST_IDLE  = 2'd0;
   localparam ST_ARMED = 2'd1;
   localparam ST_ALIGN = 2'd2;
   localparam ST_RUN   = 2'd3;

   // ==========================================
   // registers
   reg  [`CFG_WIDTH-1:0] config_reg;
   reg  [7:0]            sysref_pulse_count;
   reg  [3:0]            sysref_rate_divider;
   reg  [6:0]            coincidence_divider;
   reg  [7:0]            sysref_delay;
   reg                   sysref_release;
   reg  [1:0]            state;
   reg  [7:0]            remaining;
   reg                   powered;
   reg  [31:0]           read_mux;
   reg                   addr_ok;

   wire                  trig_rise;
   wire                  coin_tick;
   wire                  period_end;
   wire                  high_phase;
   wire                  wr_access;
   wire                  release_wr;
   wire                  sysref_source_select;
   wire                  sysref_continuous_select;
   wire                  idle_bias_on;

   assign sysref_source_select     = config_reg[`CFG_SOURCE_SELECT];
   assign sysref_continuous_select = config_reg[`CFG_CONTINUOUS_SELECT];
   assign idle_bias_on             = config_reg[`CFG_IDLE_BIAS_BIT] & config_reg[`CFG_BIAS_TYPE];

   // ==========================================
   // submodules
   trigger_sync u_trigger_sync (
      .clk         (clk),
      .rst         (rst),
      .trigger_pin (external_sysref_trigger),
      .rise        (trig_rise)
   );

   sysref_rate_gen u_rate_gen (
      .clk        (clk),
      .rst        (rst),
      .run        (state == ST_RUN),
      .rate_code  (sysref_rate_divider),
      .coin_div   (coincidence_divider),
      .coin_tick  (coin_tick),
      .period_end (period_end),
      .high_phase (high_phase)
   );

   // ==========================================
   // apb decode
   // no wait state: pready rises in the first access cycle
   assign wr_access  = psel & penable & pready & pwrite & ~pslverr;
   assign release_wr = wr_access && (paddr == `OFS_RELEASE) && pwdata[0];

   always @* begin
      addr_ok  = 1'b1;
      read_mux = 32'h00000000;
      case (paddr)
         `OFS_CONFIG:       read_mux = {26'h0000000, config_reg};
         `OFS_PULSE_COUNT:  read_mux = {24'h000000, sysref_pulse_count};
         `OFS_RATE_DIVIDER: read_mux = {28'h0000000, sysref_rate_divider};
         `OFS_COINCIDENCE:  read_mux = {25'h0000000, coincidence_divider};
         `OFS_RELEASE:      read_mux = {31'h00000000, sysref_release};
         `OFS_STATUS:       read_mux = {16'h0000, remaining, 4'h0, powered, state == ST_RUN,
                                        state == ST_ARMED, state == ST_ALIGN};
         `OFS_SYSREF_DELAY: read_mux = {24'h000000, sysref_delay};
         default:           addr_ok  = 1'b0;
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         if (psel && !penable) begin
            prdata <= addr_ok ? read_mux : 32'h00000000;
         end
      end
   end

   // ==========================================
   // register writes
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         config_reg          <= `RST_CONFIG;
         sysref_pulse_count  <= `RST_PULSE_COUNT;
         sysref_rate_divider <= `RST_RATE_DIVIDER;
         coincidence_divider <= `RST_COINCIDENCE;
         sysref_delay        <= `RST_SYSREF_DELAY;
         sysref_release      <= 1'b0;
      end else begin
         // release reads back one cycle, then clears itself
         sysref_release <= release_wr;
         if (wr_access) begin
            case (paddr)
               `OFS_CONFIG:       config_reg          <= pwdata[`CFG_WIDTH-1:0];
               `OFS_PULSE_COUNT:  sysref_pulse_count  <= pwdata[7:0];
               `OFS_RATE_DIVIDER: sysref_rate_divider <= pwdata[3:0];
               `OFS_COINCIDENCE:  coincidence_divider <= pwdata[6:0];
               `OFS_SYSREF_DELAY: sysref_delay        <= pwdata[7:0];
               default:           sysref_release      <= release_wr;
            endcase
         end
      end
   end

   // ==========================================
   // event state machine
   // shared state drives all outputs alike
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= ST_IDLE;
         remaining <= 8'h00;
         powered   <= 1'b0;
      end else if (release_wr) begin
         // a release mid-event restarts it
         powered <= 1'b0;
         if (sysref_source_select) begin
            state <= ST_ARMED;
         end else begin
            state <= ST_ALIGN;
         end
      end else begin
         case (state)
            ST_IDLE: begin
               powered <= 1'b0;
            end
            ST_ARMED: begin
               // a pin edge in the three cycles before arming still reaches here through the synchroniser
               if (trig_rise) begin
                  state <= ST_ALIGN;
               end
            end
            ST_ALIGN: begin
               if (coin_tick) begin
                  state   <= ST_RUN;
                  powered <= 1'b1;
                  // zero count treated as one pulse
                  remaining <= (sysref_pulse_count == 8'h00) ? 8'h01 : sysref_pulse_count;
               end
            end
            ST_RUN: begin
               if (period_end && !sysref_continuous_select) begin
                  remaining <= remaining - 8'h01;
                  if (remaining == 8'h01) begin
                     state   <= ST_IDLE;
                     powered <= 1'b0;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // output pins, one per sysref output
   genvar i;
   generate
      for (i = 0; i < NUM_OUTPUTS; i = i + 1) begin : g_out
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               sysref_output[i]        <= 1'b0;
               sysref_output_enable[i] <= 1'b0;
               sysref_idle_bias[i]     <= 1'b0;
            end else begin
               sysref_output[i]        <= powered & (state == ST_RUN) & high_phase;
               sysref_output_enable[i] <= powered & (state == ST_RUN);
               sysref_idle_bias[i]     <= ~(powered & (state == ST_RUN)) & idle_bias_on;
            end
         end
      end
   endgenerate

   // ==========================================
   // alignment status flags
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sysref_phase_ahead  <= 1'b1;
         deterministic_delay <= 1'b0;
      end else begin
         sysref_phase_ahead  <= (sysref_delay <= `PHASE_AHEAD_MAX);
         deterministic_delay <= ~config_reg[`CFG_VCXO_LOOP_BYPASS]
                              & config_reg[`CFG_SYNTH_LOOP_BYPASS];
      end
   end

endmodule // sysref_pulse_gen

`default_nettype wire

// ==== bench/sysref_pulse_gen_properties.sv ====
`default_nettype none
// ====================
// sysref generator checker
module sysref_pulse_gen_properties #(
   parameter NUM_OUTPUTS = 4
) (
   // clock and reset
   input wire logic                   clk,
   input wire logic                   rst,
   // apb
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pready,
   input wire logic                   pslverr,
   // sysref
   input wire logic [NUM_OUTPUTS-1:0] sysref_output,
   input wire logic [NUM_OUTPUTS-1:0] sysref_output_enable,
   input wire logic [NUM_OUTPUTS-1:0] sysref_idle_bias
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   property p_apb_access;
      s_setup |=> s_access;
   endproperty
   a_apb_access: assert property (p_apb_access) else $error("no access after setup");
   property p_ready_in_access;
      pready |-> psel && penable;
   endproperty
   a_ready_in_access: assert property (p_ready_in_access) else $error("stray ready");
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
   property p_all_equal;
      sysref_output == {NUM_OUTPUTS{sysref_output[0]}} &&
      sysref_output_enable == {NUM_OUTPUTS{sysref_output_enable[0]}};
   endproperty
   a_all_equal: assert property (p_all_equal) else $error("outputs differ");
   property p_idle_low;
      !sysref_output_enable[0] |-> sysref_output == '0;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("pulse while off");
   property p_bias_off;
      sysref_idle_bias[0] |-> !sysref_output_enable[0];
   endproperty
   a_bias_off: assert property (p_bias_off) else $error("bias while on");
   // a restart may cut a high phase short
   property p_high_width;
      $rose(sysref_output[0]) |-> (sysref_output[0] [*8]) or (##[0:7] !sysref_output_enable[0]);
   endproperty
   a_high_width: assert property (p_high_width) else $error("pulse too short");
   property p_start_high;
      $rose(sysref_output_enable[0]) |-> sysref_output[0];
   endproperty
   a_start_high: assert property (p_start_high) else $error("event not started high");
endmodule // sysref_pulse_gen_properties

bind sysref_pulse_gen sysref_pulse_gen_properties #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_props (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .sysref_output(sysref_output), .sysref_output_enable(sysref_output_enable),
   .sysref_idle_bias(sysref_idle_bias));
`default_nettype wire

// ==== bench/sysref_receiver.sv ====
`default_nettype none
// ====================
// converter-side sysref receiver
module sysref_receiver (
   // clock and reset
   input wire logic   clk,
   input wire logic   rst,
   // sysref in
   input wire logic   sref,
   input wire logic   clr,
   // measurements
   output logic [15:0] pulses,
   output logic [15:0] hi_len
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        prev;
   logic [15:0] run;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev <= 1'b0;
         pulses <= 16'h0;
         hi_len <= 16'h0;
         run <= 16'h0;
      end else begin
         prev <= sref;
         if (clr) pulses <= 16'h0;
         else if (sref && !prev) pulses <= pulses + 16'h1;
         run <= sref ? run + 16'h1 : 16'h0;
         if (!sref && prev) hi_len <= run;
      end
   end
endmodule // sysref_receiver
`default_nettype wire

// ==== bench/sysref_pulse_gen_test.sv ====
`default_nettype none
`include "sysref_defs.vh"
// ====================
// sysref generator bench
module sysref_pulse_gen_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig = 1'b0, clr = 1'b0, err;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, rdata;
   wire  [31:0] prdata;
   wire         pready, pslverr, sysref_phase_ahead, deterministic_delay;
   wire  [3:0]  sysref_output, sysref_output_enable, sysref_idle_bias;
   wire  [15:0] pulses, hi_len;
   int          fails = 0, tests_run = 0, seed = 17, i, cnt, rc;
   logic [31:0] cfg;
   logic [7:0]  ra [5] = '{`OFS_CONFIG, `OFS_PULSE_COUNT, `OFS_RATE_DIVIDER, `OFS_COINCIDENCE, `OFS_SYSREF_DELAY};
   logic [31:0] rv [5] = '{32'h0, 32'h1, 32'h0, 32'h1, 32'h0};

   sysref_pulse_gen #(.NUM_OUTPUTS(4)) u_dut (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_sysref_trigger(trig),
      .sysref_output(sysref_output), .sysref_output_enable(sysref_output_enable),
      .sysref_idle_bias(sysref_idle_bias), .sysref_phase_ahead(sysref_phase_ahead),
      .deterministic_delay(deterministic_delay));
   sysref_receiver u_rx (.clk(clk), .rst(rst), .sref(sysref_output[0]), .clr(clr), .pulses(pulses), .hi_len(hi_len));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic summarize;
      if (fails == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // codes above the table fall back to the slowest rate
   function automatic int ratio(input int c);
      int tbl [16] = '{64, 96, 128, 192, 256, 384, 512, 768, 1024, 2048, 4096, 5120, 5120, 5120, 5120, 5120};
      return tbl[c];
   endfunction

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         summarize();
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_en(input logic v);
      int n;
      n = 0;
      while (sysref_output_enable[0] !== v) begin
         @(posedge clk);
         n++;
         if (n > 20000) begin
            fails++;
            summarize();
         end
      end
   endtask

   // restart needs a few cycles to drop the old event
   task automatic run_event(input logic [31:0] cf, input logic [31:0] n, input logic [31:0] r, input logic ext);
      apb(1'b1, `OFS_CONFIG, cf);
      apb(1'b1, `OFS_PULSE_COUNT, n);
      apb(1'b1, `OFS_RATE_DIVIDER, r);
      apb(1'b1, `OFS_COINCIDENCE, 32'(($random(seed) & 3) + 1));
      apb(1'b1, `OFS_SYSREF_DELAY, 32'h1);
      clr <= 1'b1;
      apb(1'b1, `OFS_RELEASE, 32'h1);
      // clear stays over the cut tail of an earlier event
      repeat (2) @(posedge clk);
      clr <= 1'b0;
      @(posedge clk);
      if (ext) begin
         repeat (40) @(posedge clk);
         chk(sysref_output_enable, 32'h0);
         trig <= 1'b1;
         repeat (4) @(posedge clk);
         trig <= 1'b0;
      end
      wait_en(1'b1);
      chk(sysref_idle_bias, 32'h0);
      chk(sysref_phase_ahead, 32'h1);
      if (cf[1]) return;
      wait_en(1'b0);
      chk(pulses, n);
      chk(hi_len, 32'(ratio(r) / 2));
      repeat (2) @(posedge clk);
      chk(sysref_idle_bias, (cf[3:2] == 2'b11) ? 32'hf : 32'h0);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 5; i++) begin
         apb(1'b0, ra[i], 32'h0);
         chk(rdata, rv[i]);
      end
      apb(1'b0, 8'h1c, 32'h0);
      chk(err, 32'h1);
      chk(rdata, 32'h0);
      for (i = 0; i < 4; i++) begin
         cfg = i < 3 ? i : $random(seed) & 8'hff;
         apb(1'b1, `OFS_SYSREF_DELAY, cfg);
         apb(1'b1, `OFS_CONFIG, 32'(i << 4));
         repeat (2) @(posedge clk);
         chk(sysref_phase_ahead, cfg <= 1);
         chk(deterministic_delay, i == 2);
      end
      for (i = 0; i < 4; i++) begin
         cnt = i == 0 ? 1 : i == 3 ? 255 : ($random(seed) & 3) + 2;
         // single pulse may use any code, slow ones too
         rc = i == 3 ? 0 : i == 0 ? ($random(seed) & 15) : ($random(seed) & 3) % 3;
         run_event(i == 1 ? 12 : i == 2 ? 4 : 0, cnt, rc, 1'b0);
      end
      run_event(32'h2, 32'h3, 32'h0, 1'b0);
      for (i = 0; i < 2000 && pulses < 16'h6; i++) @(posedge clk);
      if (pulses < 16'h6) begin
         fails++;
         summarize();
      end
      chk(sysref_output_enable, 32'hf);
      run_event(32'h0, 32'h2, 32'h1, 1'b0);
      apb(1'b1, `OFS_CONFIG, 32'h1);
      trig <= 1'b1;
      repeat (4) @(posedge clk);
      trig <= 1'b0;
      repeat (30) @(posedge clk);
      chk(sysref_output_enable, 32'h0);
      run_event(32'h1, 32'(($random(seed) & 3) + 1), 32'h0, 1'b1);
      apb(1'b0, `OFS_RELEASE, 32'h0);
      chk(rdata, 32'h0);
      summarize();
   end
endmodule // sysref_pulse_gen_test
`default_nettype wire
